// *** asmh_pkg.sv ***
package asmh_pkg;
    // low-speed communication resource identifiers reported by the host
    localparam logic [31:0] ASMH_LSC_ID_RETURN = 32'h0060_5043;
    localparam logic [31:0] ASMH_LSC_ID_MODEM  = 32'h0060_8043;
    localparam logic [31:0] ASMH_LSC_ID_NONE   = 32'h0000_0000;

    // message tags (24 bits, sent most significant byte first)
    localparam logic [23:0] ASMH_TAG_INFO_REQ   = 24'h9F_8030;
    localparam logic [23:0] ASMH_TAG_INFO_REPLY = 24'h9F_8031;
    localparam logic [23:0] ASMH_TAG_PAL        = 24'h9F_8032;
    localparam logic [23:0] ASMH_TAG_PAL_ANSWER = 24'h9F_8033;
    localparam logic [23:0] ASMH_TAG_NOTICE     = 24'h9F_8034;

    // frame layout in bytes
    localparam logic [7:0] ASMH_INFO_REQ_LEN   = 8'h00;
    localparam logic [7:0] ASMH_PAL_LEN_SINGLE = 8'h02;
    localparam logic [7:0] ASMH_PAL_LEN_MULTI  = 8'h03;
    localparam logic [3:0] ASMH_TAG_BYTES      = 4'h3;
    localparam logic [3:0] ASMH_INFO_REQ_LAST  = 4'h3;
    localparam logic [3:0] ASMH_PAL_LAST_SGL   = 4'h5;
    localparam logic [3:0] ASMH_PAL_LAST_MUL   = 4'h6;

    typedef enum logic {ASMH_KIND_INFO, ASMH_KIND_PAL} asmh_kind_t;
    typedef enum logic [1:0] {ASMH_RX_TAG, ASMH_RX_LEN, ASMH_RX_BODY} asmh_rx_t;
endpackage : asmh_pkg

// *** asmh_host.sv ***
`timescale 1ns/10ps
module asmh_host
    import asmh_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        ARST_N,
    input  wire logic        HAS_RET_TX,
    input  wire logic        HAS_MODEM,
    input  wire logic        MULTI_MODE,
    input  wire logic        SESS_OPEN_REQ,
    input  wire logic        TX_READY,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_VALID,
    input  wire logic        PAL_REQ,
    input  wire logic [7:0]  PAL_INDEX,
    input  wire logic [15:0] PAL_PROGRAM,
    output logic      [31:0] LSC_ID,
    output logic             LSC_ID_VALID,
    output logic             SESS_OPEN,
    output logic             SESS_ACK,
    output logic             SESS_REFUSE,
    output logic      [7:0]  TX_DATA,
    output logic             TX_VALID,
    output logic             PAL_READY,
    output logic      [15:0] CODE,
    output logic             CODE_VALID,
    output logic             INFO_DONE,
    output logic             NOTICE,
    output logic             ANSWER,
    output logic      [7:0]  RX_INDEX
);
    logic [31:0] lsc_id_ff;
    logic        lsc_valid_ff;
    logic        open_ff;
    logic        ack_ff;
    logic        refuse_ff;
    logic        inq_sent_ff;
    logic [7:0]  tx_data_ff;
    logic        tx_valid_ff;
    logic [3:0]  tx_cnt_ff;
    asmh_kind_t  tx_kind_ff;
    logic        multi_ff;
    logic [7:0]  pal_idx_ff;
    logic [15:0] pal_prog_ff;
    logic        pal_ready_ff;
    asmh_rx_t    rx_state_ff;
    logic [1:0]  rx_cnt_ff;
    logic [23:0] rx_tag_ff;
    logic [7:0]  rx_left_ff;
    logic        rx_first_ff;
    logic        rx_odd_ff;
    logic [7:0]  code_hi_ff;
    logic [15:0] code_ff;
    logic        code_valid_ff;
    logic        info_done_ff;
    logic        notice_ff;
    logic        answer_ff;
    logic [7:0]  rx_index_ff;

    // byte i of an outgoing frame; data sent MSB first
    function automatic logic [7:0] asmh_tx_byte(input asmh_kind_t kind, input logic [3:0] i,
                                                input logic multi, input logic [7:0] idx,
                                                input logic [15:0] prog);
        logic [23:0] tag;
        logic [3:0]  p;
        tag = (kind == ASMH_KIND_INFO) ? ASMH_TAG_INFO_REQ : ASMH_TAG_PAL;
        p   = multi ? (i - 4'h1) : i;
        if (i == 4'h0) begin
            asmh_tx_byte = tag[23:16];
        end else if (i == 4'h1) begin
            asmh_tx_byte = tag[15:8];
        end else if (i == 4'h2) begin
            asmh_tx_byte = tag[7:0];
        end else if (kind == ASMH_KIND_INFO) begin
            asmh_tx_byte = ASMH_INFO_REQ_LEN;
        end else if (i == ASMH_TAG_BYTES) begin
            asmh_tx_byte = multi ? ASMH_PAL_LEN_MULTI : ASMH_PAL_LEN_SINGLE;
        end else if (multi && i == 4'h4) begin
            asmh_tx_byte = idx;
        end else if (p == 4'h4) begin
            asmh_tx_byte = prog[15:8];
        end else begin
            asmh_tx_byte = prog[7:0];
        end
    endfunction : asmh_tx_byte

    // identifier matrix; a modem without a transmitter reports nothing
    wire        strap_ret   = HAS_RET_TX;
    wire [31:0] nxt_lsc_id  = !strap_ret ? ASMH_LSC_ID_NONE :
                              HAS_MODEM  ? ASMH_LSC_ID_MODEM :
                                           ASMH_LSC_ID_RETURN;
    wire        nxt_lsc_val = strap_ret;

    // the card owns the open; the host grants only the first one
    wire        sess_grant  = SESS_OPEN_REQ && !open_ff;
    wire        sess_refuse = SESS_OPEN_REQ && open_ff;

    wire        tx_take     = tx_valid_ff && TX_READY;
    wire [3:0]  tx_last     = (tx_kind_ff == ASMH_KIND_INFO) ? ASMH_INFO_REQ_LAST :
                              multi_ff ? ASMH_PAL_LAST_MUL : ASMH_PAL_LAST_SGL;
    wire        tx_done     = tx_take && (tx_cnt_ff == tx_last);
    wire        tx_idle     = !tx_valid_ff || tx_done;
    wire        start_inq   = open_ff && !inq_sent_ff && tx_idle;
    wire        start_pal   = PAL_REQ && pal_ready_ff && !start_inq;
    wire [3:0]  nxt_tx_cnt  = (start_inq || start_pal) ? 4'h0 : (tx_cnt_ff + 4'h1);
    wire [7:0]  nxt_tx_data = start_inq ? asmh_tx_byte(ASMH_KIND_INFO, 4'h0, 1'b0, 8'h00,
                                                       16'h0000) :
                              start_pal ? asmh_tx_byte(ASMH_KIND_PAL, 4'h0, MULTI_MODE, PAL_INDEX,
                                                       PAL_PROGRAM) :
                              asmh_tx_byte(tx_kind_ff, nxt_tx_cnt, multi_ff, pal_idx_ff,
                                           pal_prog_ff);
    // the list is offered only on an idle link after the info request is out
    wire        nxt_pal_rdy = open_ff && inq_sent_ff && !start_pal && tx_idle;

    // receive parser: tag, one-byte length, body
    wire        rx_in_body  = RX_VALID && (rx_state_ff == ASMH_RX_BODY);
    wire        rx_len_zero = RX_VALID && (rx_state_ff == ASMH_RX_LEN) && (RX_DATA == 8'h00);
    wire        rx_end      = rx_len_zero || (rx_in_body && rx_left_ff == 8'h01);
    wire        is_info     = (rx_tag_ff == ASMH_TAG_INFO_REPLY);
    wire        is_answer   = (rx_tag_ff == ASMH_TAG_PAL_ANSWER);
    wire        is_notice   = (rx_tag_ff == ASMH_TAG_NOTICE);
    // codes pair high byte then low byte; a lone trailing byte is dropped
    wire        code_pair   = rx_in_body && is_info && rx_odd_ff;
    wire        idx_take    = rx_in_body && rx_first_ff && multi_ff && (is_answer || is_notice);
    wire [23:0] nxt_rx_tag  = {rx_tag_ff[15:0], RX_DATA};
    // outgoing data comes only from this controller; no out-of-band data enters the link
    // every elementary stream is passed unfiltered, so no stream-identifier exchange runs

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lsc_id_ff    <= ASMH_LSC_ID_NONE;
            lsc_valid_ff <= 1'b0;
            open_ff      <= 1'b0;
            ack_ff       <= 1'b0;
            refuse_ff    <= 1'b0;
        end else begin
            lsc_id_ff    <= nxt_lsc_id;
            lsc_valid_ff <= nxt_lsc_val;
            open_ff      <= open_ff || sess_grant;
            ack_ff       <= sess_grant;
            refuse_ff    <= sess_refuse;
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            inq_sent_ff  <= 1'b0;
            tx_data_ff   <= 8'h00;
            tx_valid_ff  <= 1'b0;
            tx_cnt_ff    <= 4'h0;
            tx_kind_ff   <= ASMH_KIND_INFO;
            multi_ff     <= 1'b0;
            pal_idx_ff   <= 8'h00;
            pal_prog_ff  <= 16'h0000;
            pal_ready_ff <= 1'b0;
        end else begin
            pal_ready_ff <= nxt_pal_rdy;
            if (start_inq) begin
                inq_sent_ff <= 1'b1;
                tx_kind_ff  <= ASMH_KIND_INFO;
            end
            if (start_pal) begin
                tx_kind_ff  <= ASMH_KIND_PAL;
                multi_ff    <= MULTI_MODE;
                pal_idx_ff  <= PAL_INDEX;
                pal_prog_ff <= PAL_PROGRAM;
            end
            if (start_inq || start_pal || (tx_take && !tx_done)) begin
                tx_cnt_ff   <= nxt_tx_cnt;
                tx_data_ff  <= nxt_tx_data;
                tx_valid_ff <= 1'b1;
            end else if (tx_done) begin
                tx_valid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_state_ff <= ASMH_RX_TAG;
            rx_cnt_ff   <= 2'h0;
            rx_tag_ff   <= 24'h00_0000;
            rx_left_ff  <= 8'h00;
            rx_first_ff <= 1'b0;
            rx_odd_ff   <= 1'b0;
        end else if (RX_VALID) begin
            unique case (rx_state_ff)
                ASMH_RX_TAG: begin
                    rx_tag_ff <= nxt_rx_tag;
                    rx_cnt_ff <= rx_cnt_ff + 2'h1;
                    if (rx_cnt_ff == 2'h2) begin
                        rx_cnt_ff   <= 2'h0;
                        rx_state_ff <= ASMH_RX_LEN;
                    end
                end
                ASMH_RX_LEN: begin
                    rx_left_ff  <= RX_DATA;
                    rx_first_ff <= 1'b1;
                    rx_odd_ff   <= 1'b0;
                    rx_state_ff <= rx_len_zero ? ASMH_RX_TAG : ASMH_RX_BODY;
                end
                ASMH_RX_BODY: begin
                    rx_left_ff  <= rx_left_ff - 8'h01;
                    rx_first_ff <= 1'b0;
                    rx_odd_ff   <= !rx_odd_ff;
                    if (rx_end) begin
                        rx_state_ff <= ASMH_RX_TAG;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            code_hi_ff    <= 8'h00;
            code_ff       <= 16'h0000;
            code_valid_ff <= 1'b0;
            info_done_ff  <= 1'b0;
            notice_ff     <= 1'b0;
            answer_ff     <= 1'b0;
            rx_index_ff   <= 8'h00;
        end else begin
            code_valid_ff <= code_pair;
            info_done_ff  <= rx_end && is_info;
            notice_ff     <= rx_end && is_notice;
            answer_ff     <= rx_end && is_answer;
            if (rx_in_body && !rx_odd_ff) begin
                code_hi_ff <= RX_DATA;
            end
            if (code_pair) begin
                code_ff <= {code_hi_ff, RX_DATA};
            end
            if (rx_len_zero || (RX_VALID && rx_state_ff == ASMH_RX_LEN && !multi_ff)) begin
                rx_index_ff <= 8'h00;
            end else if (idx_take) begin
                rx_index_ff <= RX_DATA;
            end
        end
    end

    assign LSC_ID       = lsc_id_ff;
    assign LSC_ID_VALID = lsc_valid_ff;
    assign SESS_OPEN    = open_ff;
    assign SESS_ACK     = ack_ff;
    assign SESS_REFUSE  = refuse_ff;
    assign TX_DATA      = tx_data_ff;
    assign TX_VALID     = tx_valid_ff;
    assign PAL_READY    = pal_ready_ff;
    assign CODE         = code_ff;
    assign CODE_VALID   = code_valid_ff;
    assign INFO_DONE    = info_done_ff;
    assign NOTICE       = notice_ff;
    assign ANSWER       = answer_ff;
    assign RX_INDEX     = rx_index_ff;

    default clocking asmh_cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    sequence notice_end_s;
        rx_end && is_notice;
    endsequence
    sequence notice_seen_s;
        ##1 NOTICE ##1 !NOTICE || rx_end;
    endsequence

    lsc_return_a: assert property (
        HAS_RET_TX && !HAS_MODEM |=> LSC_ID_VALID && LSC_ID == ASMH_LSC_ID_RETURN)
        else $error("wrong return id");
    lsc_modem_a: assert property (
        HAS_RET_TX && HAS_MODEM |=> LSC_ID_VALID && LSC_ID == ASMH_LSC_ID_MODEM)
        else $error("wrong modem id");
    lsc_none_a: assert property (
        !HAS_RET_TX |=> !LSC_ID_VALID && LSC_ID == ASMH_LSC_ID_NONE)
        else $error("id without transmitter");
    one_session_a: assert property (
        SESS_OPEN_REQ && SESS_OPEN |=> SESS_REFUSE && !SESS_ACK)
        else $error("second session granted");
    stay_open_a: assert property (SESS_OPEN |=> SESS_OPEN) else $error("session closed");
    tx_hold_a: assert property (
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("tx byte dropped");
    inq_zero_a: assert property (
        TX_VALID && tx_kind_ff == ASMH_KIND_INFO && tx_cnt_ff == ASMH_INFO_REQ_LAST
        |-> TX_DATA == ASMH_INFO_REQ_LEN)
        else $error("request length not zero");
    inq_after_open_a: assert property (
        $rose(SESS_OPEN) |-> ##[0:8] (TX_VALID && TX_DATA == 8'h9F))
        else $error("no info request");
    pal_index_a: assert property (
        TX_VALID && tx_kind_ff == ASMH_KIND_PAL && multi_ff && tx_cnt_ff == 4'h4
        |-> TX_DATA == pal_idx_ff)
        else $error("index missing");
    notice_seen_a: assert property (
        notice_end_s |-> notice_seen_s)
        else $error("notice not raised");
endmodule : asmh_host

// *** asmh_card_model.sv ***
`timescale 1ns/10ps
module asmh_card_model
    import asmh_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       slow,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            open_req
);
    logic [7:0] host_q[$];

    initial begin
        rx_data  = 8'hA5;
        rx_valid = 1'b0;
        open_req = 1'b0;
    end

    // alternate-cycle stall in slow mode forces the host to hold its byte
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready <= 1'b0;
        end else begin
            if (tx_valid && tx_ready) host_q.push_back(tx_data);
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
    end

    // the card never closes its one session; extra attempts come from the bench
    task automatic open_session();
        @(posedge core_clk) #1;
        open_req = 1'b1;
        @(posedge core_clk) #1;
        open_req = 1'b0;
    endtask : open_session

    task automatic send_frame(input logic [23:0] tag, input logic [7:0] body[$]);
        logic [7:0] bytes[$];
        bytes = {tag[23:16], tag[15:8], tag[7:0], 8'(body.size())};
        bytes = {bytes, body};
        foreach (bytes[i]) begin
            @(posedge core_clk) #1;
            rx_data  = bytes[i];
            rx_valid = 1'b1;
            if (slow) begin
                @(posedge core_clk) #1;
                rx_valid = 1'b0;
                rx_data  = ~bytes[i];
            end
        end
        @(posedge core_clk) #1;
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
    endtask : send_frame

    task automatic reply_info(input logic [15:0] codes[$]);
        logic [7:0] body[$];
        foreach (codes[i]) body = {body, codes[i][15:8], codes[i][7:0]};
        send_frame(ASMH_TAG_INFO_REPLY, body);
    endtask : reply_info

    task automatic send_indexed(input logic [23:0] tag, input logic [7:0] idx);
        send_frame(tag, {idx});
    endtask : send_indexed
endmodule : asmh_card_model

// *** asmh_host_tb_top.sv ***
`timescale 1ns/10ps
module asmh_host_tb_top;
    import asmh_pkg::*;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        has_ret_tx = 1'b0;
    logic        has_modem = 1'b0;
    logic        multi_mode = 1'b0;
    logic        slow = 1'b0;
    logic        pal_req = 1'b0;
    logic [7:0]  pal_index = 8'h00;
    logic [15:0] pal_program = 16'h0000;
    logic        open_req, tx_ready, rx_valid, tx_valid, pal_ready;
    logic [7:0]  rx_data, tx_data, rx_index;
    logic [31:0] lsc_id;
    logic        lsc_id_valid, sess_open, sess_ack, sess_refuse;
    logic [15:0] code;
    logic        code_valid, info_done, notice, answer;
    logic [15:0] code_q[$];
    int          fails = 0, num_checks = 0;
    int          info_cnt = 0, notice_cnt = 0, answer_cnt = 0, ack_cnt = 0, ref_cnt = 0;

    always #10 core_clk = ~core_clk;

    asmh_host asmh_host_inst (.CORE_CLK(core_clk), .ARST_N(arst_n), .HAS_RET_TX(has_ret_tx),
        .HAS_MODEM(has_modem), .MULTI_MODE(multi_mode), .SESS_OPEN_REQ(open_req),
        .TX_READY(tx_ready), .RX_DATA(rx_data), .RX_VALID(rx_valid), .PAL_REQ(pal_req),
        .PAL_INDEX(pal_index), .PAL_PROGRAM(pal_program), .LSC_ID(lsc_id),
        .LSC_ID_VALID(lsc_id_valid), .SESS_OPEN(sess_open), .SESS_ACK(sess_ack),
        .SESS_REFUSE(sess_refuse), .TX_DATA(tx_data), .TX_VALID(tx_valid),
        .PAL_READY(pal_ready), .CODE(code), .CODE_VALID(code_valid), .INFO_DONE(info_done),
        .NOTICE(notice), .ANSWER(answer), .RX_INDEX(rx_index));

    asmh_card_model asmh_card_model_inst (.core_clk(core_clk), .arst_n(arst_n), .slow(slow),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .open_req(open_req));

    // pulses are one cycle wide, so they are counted where they stand
    always @(posedge core_clk) begin
        if (code_valid === 1'b1) code_q.push_back(code);
        if (info_done === 1'b1) info_cnt++;
        if (notice === 1'b1) notice_cnt++;
        if (answer === 1'b1) answer_cnt++;
        if (sess_ack === 1'b1) ack_cnt++;
        if (sess_refuse === 1'b1) ref_cnt++;
    end

    task automatic conclude();
        if (fails == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task automatic check_bytes(input string name, input logic [7:0] exp[$]);
        wait_bytes(exp.size());
        check_val({name, " count"}, exp.size(), asmh_card_model_inst.host_q.size());
        foreach (exp[i]) check_val(name, exp[i], asmh_card_model_inst.host_q[i]);
        asmh_card_model_inst.host_q.delete();
    endtask : check_bytes

    task automatic wait_bytes(input int n);
        for (int k = 0; k < 400 && asmh_card_model_inst.host_q.size() < n; k++)
            @(posedge core_clk) #1;
        repeat (4) @(posedge core_clk) #1;
        if (asmh_card_model_inst.host_q.size() < n) begin
            check_val("byte wait", n, asmh_card_model_inst.host_q.size());
            conclude();
        end
    endtask : wait_bytes

    task automatic t_straps();
        logic [31:0] ids[4] = '{ASMH_LSC_ID_NONE, ASMH_LSC_ID_NONE,
                                ASMH_LSC_ID_RETURN, ASMH_LSC_ID_MODEM};
        for (int i = 0; i < 4; i++) begin
            has_ret_tx = i[1];
            has_modem  = i[0];
            repeat (2) @(posedge core_clk) #1;
            check_val("lsc_id", ids[i], lsc_id);
            check_val("lsc_id_valid", 32'(i[1]), 32'(lsc_id_valid));
        end
    endtask : t_straps

    task automatic t_session();
        slow = 1'b1;
        check_val("pal_ready idle", 32'h0, 32'(pal_ready));
        asmh_card_model_inst.open_session();
        repeat (2) @(posedge core_clk) #1;
        check_val("sess_ack", 32'h1, ack_cnt);
        check_bytes("info_request", {8'h9F, 8'h80, 8'h30, 8'h00});
        asmh_card_model_inst.open_session();
        asmh_card_model_inst.open_session();
        repeat (2) @(posedge core_clk) #1;
        check_val("sess_refuse", 32'h2, ref_cnt);
        check_val("sess_open", 32'h1, 32'(sess_open));
    endtask : t_session

    task automatic t_info();
        asmh_card_model_inst.reply_info({16'h0B00, 16'h1234});
        repeat (2) @(posedge core_clk) #1;
        check_val("codes", 32'h2, code_q.size());
        check_val("code0", 32'h0B00, code_q[0]);
        check_val("code1", 32'h1234, code_q[1]);
        check_val("info_done", 32'h1, info_cnt);
        check_val("rx_index", 32'h0, rx_index);
    endtask : t_info

    task automatic t_pal(input logic multi, input logic [7:0] idx, input logic [15:0] prog);
        logic [7:0] exp[$];
        multi_mode  = multi;
        pal_index   = idx;
        pal_program = prog;
        for (int k = 0; k < 400 && pal_ready !== 1'b1; k++) @(posedge core_clk) #1;
        if (pal_ready !== 1'b1) begin
            check_val("pal_ready wait", 32'h1, 32'(pal_ready));
            conclude();
        end
        @(posedge core_clk) #1;
        pal_req = 1'b1;
        @(posedge core_clk) #1;
        pal_req = 1'b0;
        check_val("pal_ready taken", 32'h0, 32'(pal_ready));
        if (multi) exp = {8'h9F, 8'h80, 8'h32, ASMH_PAL_LEN_MULTI, idx, prog[15:8], prog[7:0]};
        else exp = {8'h9F, 8'h80, 8'h32, ASMH_PAL_LEN_SINGLE, prog[15:8], prog[7:0]};
        check_bytes("pal_list", exp);
        check_val("pal_ready again", 32'h1, 32'(pal_ready));
    endtask : t_pal

    task automatic t_indexed();
        asmh_card_model_inst.send_indexed(ASMH_TAG_PAL_ANSWER, 8'h07);
        repeat (2) @(posedge core_clk) #1;
        check_val("answer", 32'h1, answer_cnt);
        check_val("rx_index", 32'h07, rx_index);
        asmh_card_model_inst.send_indexed(ASMH_TAG_NOTICE, 8'h09);
        repeat (2) @(posedge core_clk) #1;
        check_val("notice", 32'h1, notice_cnt);
        check_val("rx_index", 32'h09, rx_index);
    endtask : t_indexed

    initial begin
        repeat (8) @(posedge core_clk);
        #1 arst_n = 1'b1;
        t_straps();
        t_session();
        slow = 1'b0;
        t_info();
        slow = 1'b1;
        t_pal(1'b0, 8'h05, 16'hA1B2);
        t_pal(1'b1, 8'h07, 16'h0C0D);
        t_indexed();
        conclude();
    end
endmodule : asmh_host_tb_top
